// *** t1pei_pkg.sv ***
// t1pei_pkg: register map, field layout and reset values of the payload error inserter
// assumes an AXI4-Lite master that places each 8-bit register in one aligned word
package t1pei_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_RATE_CTRL   = 8'hEB;
    localparam logic [7:0] IDX_COUNT_LOW   = 8'hEC;
    localparam logic [7:0] IDX_COUNT_HIGH  = 8'hED;
    localparam logic [7:0] IDX_REMAIN_LOW  = 8'hEE;
    localparam logic [7:0] IDX_REMAIN_HIGH = 8'hEF;
    localparam logic [7:0] IDX_CONFIG      = 8'hF0;
    localparam logic [7:0] IDX_CHAN_MASK   = 8'hF1;
    // rate control fields
    localparam int CTRL_RATE_LSB = 0;
    localparam int CTRL_RATE_W   = 4;
    localparam int CTRL_CONT_BIT = 4;
    localparam int CTRL_LOAD_BIT = 7;
    // configuration fields
    localparam int CFG_T1_BIT    = 0;
    localparam int CFG_CHSEL_BIT = 1;
    // count layout
    localparam int COUNT_W      = 10;
    localparam int COUNT_LOW_W  = 8;
    localparam int COUNT_HIGH_W = 2;
    // rate code n selects one error in 2^(n+RATE_EXP_OFFSET) bits
    localparam logic [4:0] RATE_EXP_OFFSET = 5'h03;
    localparam int BITCNT_W = 18;
    // reset values
    localparam logic [7:0]  RST_RATE_CTRL = 8'h00;
    localparam logic [7:0]  RST_COUNT_LOW = 8'h00;
    localparam logic [1:0]  RST_COUNT_HIGH = 2'h0;
    localparam logic [1:0]  RST_CONFIG = 2'h0;
    localparam logic [23:0] RST_CHAN_MASK = 24'h000000;
    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** t1pei_engine.sv ***
// t1pei_engine: counts payload bits and inverts the last bit of each interval
// assumes one payload bit per in_valid pulse, with framing bits and frame start marked
`timescale 1ns/1ns
module t1pei_engine #(
    parameter int CHANNELS = 24
) (
    // clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // configuration
    input  wire logic [3:0]                    rate_select,
    input  wire logic                          continuous,
    input  wire logic                          t1_mode,
    input  wire logic                          chan_sel_en,
    input  wire logic [CHANNELS-1:0]           chan_mask,
    input  wire logic                          load_pulse,
    input  wire logic [t1pei_pkg::COUNT_W-1:0] load_count,
    // payload stream in
    input  wire logic                          in_valid,
    input  wire logic                          in_bit,
    input  wire logic                          in_fbit,
    input  wire logic                          in_frame_start,
    input  wire logic [4:0]                    in_channel,
    // payload stream out
    output logic                               out_valid,
    output logic                               out_bit,
    output logic                               out_inserted,
    output logic [t1pei_pkg::COUNT_W-1:0]      remaining
);
    if (CHANNELS < 1 || CHANNELS > 32) begin : g_bad_channels
        $error("t1pei_engine: CHANNELS out of range");
    end

    logic [3:0]                      rate_reg;
    logic [t1pei_pkg::BITCNT_W-1:0]  bitcnt_reg;
    logic [t1pei_pkg::BITCNT_W:0]    limit;
    logic                            chan_ok;
    logic                            armed;
    logic                            counted;
    logic                            hit;

    assign limit   = (19'h00001 << ({1'b0, rate_reg} + t1pei_pkg::RATE_EXP_OFFSET)) - 19'h00001;
    assign chan_ok = !chan_sel_en || ((32'(in_channel) < CHANNELS) && chan_mask[in_channel]);
    assign armed   = t1_mode && (rate_reg != 4'h0) && (continuous || remaining != '0);
    assign counted = in_valid && !in_fbit && chan_ok && armed;
    assign hit     = counted && ({1'b0, bitcnt_reg} >= limit);

    ////////////////////////////////////////////////////////////////////////////
    // rate takes effect at frame boundaries only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rate_reg <= 4'h0;
        end else if (in_frame_start) begin
            rate_reg <= rate_select;
        end
    end

    // interval counter
    always_ff @(posedge aclk) begin
        if (!aresetn || load_pulse) begin
            bitcnt_reg <= '0;
        end else if (hit) begin
            bitcnt_reg <= '0;
        end else if (counted) begin
            bitcnt_reg <= bitcnt_reg + 18'h00001;
        end
    end

    // remaining-error counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            remaining <= '0;
        end else if (load_pulse) begin
            remaining <= load_count;
        end else if (hit && !continuous) begin
            remaining <= remaining - 10'h001;
        end
    end

    // output stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_valid    <= 1'b0;
            out_bit      <= 1'b0;
            out_inserted <= 1'b0;
        end else begin
            out_valid    <= in_valid;
            out_bit      <= in_bit ^ hit;
            out_inserted <= hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_fbit_never_hit: assert property (in_valid && in_fbit |=> !out_inserted && out_bit == $past(in_bit))
        else $error("framing bit was altered");
    a_zero_rate_quiet: assert property (rate_reg == 4'h0 |=> !out_inserted)
        else $error("error inserted at zero rate");
    a_mode_gate: assert property (!t1_mode |=> !out_inserted)
        else $error("error inserted outside T1 mode");
    a_load_value: assert property (load_pulse |=> remaining == $past(load_count))
        else $error("count not loaded");
    a_count_decr: assert property (hit && !continuous && !load_pulse |=> remaining == $past(remaining) - 10'h001)
        else $error("remaining not decremented");
    a_stop_at_zero: assert property (!continuous && remaining == '0 |=> !out_inserted)
        else $error("insertion past zero count");
    a_rate_hold: assert property (!in_frame_start |=> $stable(rate_reg))
        else $error("rate changed mid frame");
    a_interval_len: assert property (hit |-> bitcnt_reg == limit[t1pei_pkg::BITCNT_W-1:0] || $past(load_pulse))
        else $error("inversion not at interval end");
endmodule // t1pei_engine

// *** t1pei_top.sv ***
// t1pei_top: AXI4-Lite register file and payload error inserter for the T1 transmit path
// assumes the transmit formatter marks each payload bit, framing bits and frame starts
// Functional notes
// - insertion acts only in T1 mode; otherwise bits pass unchanged
// - errors hit whole payload or only host-selected channels
// - each error inverts the last bit of the counting interval
// - framing bits are not counted and never inverted
// - a new rate takes effect only at a frame boundary
// - rate code 0 means off; code n gives one error per 2^(n+3) bits
// - rate zero generates no errors even in continuous mode
// - continuous mode with nonzero rate ignores the count and inserts forever
// - counted mode inserts only the loaded number of errors, then stops
// - rising load strobe moves held count into the inserter two cycles later
// - holding the strobe high never reloads; only a new rising edge does
// - ten-bit count: low register bits 0-7, high register bits 8-9
// - count zero makes no errors in counted mode; read-back gives errors still remaining
// - remaining count is readable anytime in two registers after the count registers
`timescale 1ns/1ns
module t1pei_top #(
    parameter int ADDR_W   = 12,
    parameter int CHANNELS = 24
) (
    // clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // payload stream from the transmit formatter
    input  wire logic                tx_valid,
    input  wire logic                tx_bit,
    input  wire logic                tx_fbit,
    input  wire logic                tx_frame_start,
    input  wire logic [4:0]          tx_channel,
    // payload stream toward the line side
    output logic                     line_valid,
    output logic                     line_bit,
    output logic                     line_error_inserted
);
    if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr_w
        $error("t1pei_top: ADDR_W out of range");
    end
    if (CHANNELS < 1 || CHANNELS > 24) begin : g_bad_channels
        $error("t1pei_top: CHANNELS out of range");
    end

    logic [7:0]                       error_rate_control_reg;
    logic [7:0]                       error_count_low_reg;
    logic [1:0]                       error_count_high_reg;
    logic [1:0]                       config_reg;
    logic [CHANNELS-1:0]              chan_mask_reg;
    logic                             strobe_prev_reg;
    logic                             load_pulse_reg;
    logic [t1pei_pkg::COUNT_W-1:0]    remaining;

    logic [ADDR_W-1:0]                aw_addr_reg;
    logic                             aw_held_reg;
    logic [31:0]                      w_data_reg;
    logic [3:0]                       w_strb_reg;
    logic                             w_held_reg;
    logic                             wr_fire;
    logic [7:0]                       wr_idx;
    logic                             wr_hit;
    logic [7:0]                       rd_idx;
    logic                             rd_hit;
    logic [31:0]                      rd_word;

    ////////////////////////////////////////////////////////////////////////////
    // write channels: address and data taken in either order
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_idx        = aw_addr_reg[9:2];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    always_comb begin
        wr_hit = 1'b0;
        case (wr_idx)
            t1pei_pkg::IDX_RATE_CTRL, t1pei_pkg::IDX_COUNT_LOW, t1pei_pkg::IDX_COUNT_HIGH,
            t1pei_pkg::IDX_CONFIG, t1pei_pkg::IDX_CHAN_MASK: begin
                wr_hit = (aw_addr_reg[1:0] == 2'h0) && (32'(aw_addr_reg >> 10) == 0);
            end
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= t1pei_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? t1pei_pkg::RESP_OKAY : t1pei_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register file
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            error_rate_control_reg <= t1pei_pkg::RST_RATE_CTRL;
            error_count_low_reg    <= t1pei_pkg::RST_COUNT_LOW;
            error_count_high_reg   <= t1pei_pkg::RST_COUNT_HIGH;
            config_reg             <= t1pei_pkg::RST_CONFIG;
        end else if (wr_fire && wr_hit && w_strb_reg[0]) begin
            case (wr_idx)
                t1pei_pkg::IDX_RATE_CTRL:  error_rate_control_reg <= w_data_reg[7:0];
                t1pei_pkg::IDX_COUNT_LOW:  error_count_low_reg <= w_data_reg[7:0];
                t1pei_pkg::IDX_COUNT_HIGH: error_count_high_reg <= w_data_reg[1:0];
                t1pei_pkg::IDX_CONFIG:     config_reg <= w_data_reg[1:0];
                default: ;
            endcase
        end
    end

    // channel mask, one bit per channel, byte lanes honoured
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_mask
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    chan_mask_reg[gi] <= t1pei_pkg::RST_CHAN_MASK[gi];
                end else if (wr_fire && wr_hit && wr_idx == t1pei_pkg::IDX_CHAN_MASK && w_strb_reg[gi/8]) begin
                    chan_mask_reg[gi] <= w_data_reg[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // load strobe edge detection: a pulse one cycle after the rising write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strobe_prev_reg <= 1'b0;
            load_pulse_reg  <= 1'b0;
        end else begin
            strobe_prev_reg <= error_rate_control_reg[t1pei_pkg::CTRL_LOAD_BIT];
            load_pulse_reg  <= error_rate_control_reg[t1pei_pkg::CTRL_LOAD_BIT] && !strobe_prev_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channel
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_idx        = s_axi_araddr[9:2];

    always_comb begin
        rd_word = 32'h00000000;
        rd_hit  = (s_axi_araddr[1:0] == 2'h0) && (32'(s_axi_araddr >> 10) == 0);
        case (rd_idx)
            t1pei_pkg::IDX_RATE_CTRL:   rd_word[7:0] = error_rate_control_reg;
            t1pei_pkg::IDX_COUNT_LOW:   rd_word[7:0] = error_count_low_reg;
            t1pei_pkg::IDX_COUNT_HIGH:  rd_word[1:0] = error_count_high_reg;
            t1pei_pkg::IDX_REMAIN_LOW:  rd_word[7:0] = remaining[7:0];
            t1pei_pkg::IDX_REMAIN_HIGH: rd_word[1:0] = remaining[9:8];
            t1pei_pkg::IDX_CONFIG:      rd_word[1:0] = config_reg;
            t1pei_pkg::IDX_CHAN_MASK:   rd_word[CHANNELS-1:0] = chan_mask_reg;
            default:                    rd_hit = 1'b0;
        endcase
        if (!rd_hit) begin
            rd_word = 32'h00000000;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= t1pei_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? t1pei_pkg::RESP_OKAY : t1pei_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // insertion engine
    t1pei_engine #(
        .CHANNELS (CHANNELS)
    ) u_engine (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .rate_select    (error_rate_control_reg[t1pei_pkg::CTRL_RATE_LSB +: t1pei_pkg::CTRL_RATE_W]),
        .continuous     (error_rate_control_reg[t1pei_pkg::CTRL_CONT_BIT]),
        .t1_mode        (config_reg[t1pei_pkg::CFG_T1_BIT]),
        .chan_sel_en    (config_reg[t1pei_pkg::CFG_CHSEL_BIT]),
        .chan_mask      (chan_mask_reg),
        .load_pulse     (load_pulse_reg),
        .load_count     ({error_count_high_reg, error_count_low_reg}),
        .in_valid       (tx_valid),
        .in_bit         (tx_bit),
        .in_fbit        (tx_fbit),
        .in_frame_start (tx_frame_start),
        .in_channel     (tx_channel),
        .out_valid      (line_valid),
        .out_bit        (line_bit),
        .out_inserted   (line_error_inserted),
        .remaining      (remaining)
    );

    ////////////////////////////////////////////////////////////////////////////
    sequence s_strobe_rise;
        !error_rate_control_reg[t1pei_pkg::CTRL_LOAD_BIT] ##1 error_rate_control_reg[t1pei_pkg::CTRL_LOAD_BIT];
    endsequence

    a_load_on_edge: assert property (@(posedge aclk) disable iff (!aresetn)
        s_strobe_rise |=> load_pulse_reg ##1 remaining == $past({error_count_high_reg, error_count_low_reg}))
        else $error("rising strobe did not load count");
    a_no_reload_high: assert property (@(posedge aclk) disable iff (!aresetn)
        error_rate_control_reg[t1pei_pkg::CTRL_LOAD_BIT] [*2] |=> !load_pulse_reg)
        else $error("held strobe reloaded count");
    a_remain_read: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && rd_idx == t1pei_pkg::IDX_REMAIN_LOW && rd_hit
        |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(remaining[7:0]))
        else $error("remaining count read wrong");
    a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire |=> s_axi_bvalid)
        else $error("write not answered");
endmodule // t1pei_top

// *** t1pei_stream_src.sv ***
// t1pei_stream_src: behavioural transmit formatter, one T1 frame bit per cycle while run is high
// assumes the bench raises and lowers run just after a clock edge
`timescale 1ns/1ns
module t1pei_stream_src (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // control
    input  wire logic       run,
    // payload stream
    output logic            tx_valid,
    output logic            tx_bit,
    output logic            tx_fbit,
    output logic            tx_frame_start,
    output logic [4:0]      tx_channel
);
    logic [7:0] pos_reg;
    ////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pos_reg <= 8'h00;
            tx_valid <= 1'b0;
            tx_bit <= 1'b0;
            tx_fbit <= 1'b0;
            tx_frame_start <= 1'b0;
            tx_channel <= 5'h00;
        end else if (!run) begin
            // idle: qualifiers low, data lines keep moving
            pos_reg <= 8'h00;
            tx_valid <= 1'b0;
            tx_fbit <= 1'b0;
            tx_frame_start <= 1'b0;
            tx_bit <= ~tx_bit;
            tx_channel <= tx_channel + 5'h01;
        end else begin
            // framing bit leads each 193-bit frame
            tx_valid <= 1'b1;
            tx_fbit <= (pos_reg == 8'h00);
            tx_frame_start <= (pos_reg == 8'h00);
            tx_channel <= (pos_reg == 8'h00) ? 5'h1F : 5'((pos_reg - 8'h01) >> 3);
            tx_bit <= pos_reg[0] ^ pos_reg[2];
            pos_reg <= (pos_reg == 8'hC0) ? 8'h00 : pos_reg + 8'h01;
        end
    end
endmodule // t1pei_stream_src

// *** t1_payload_error_inserter_bench.sv ***
// t1_payload_error_inserter_bench: register and stream tests of the payload error inserter
// assumes the stream source model supplies whole frames while run is high
`timescale 1ns/1ns
module t1_payload_error_inserter_bench;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic        awvalid = 1'b0;
    logic        awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  strb = 4'hF;
    logic        wvalid = 1'b0;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready = 1'b0;
    logic [11:0] araddr = 12'h000;
    logic        arvalid = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready = 1'b0;
    logic        run = 1'b0;
    logic        tx_valid, tx_bit, tx_fbit, tx_frame_start, line_valid, line_bit, line_err, d_bit, d_fbit, d_val;
    logic [4:0]  tx_channel, d_ch;
    logic [1:0]  resp;
    int          err_count = 0;
    int          tests_run = 0;
    int          cnt, errs, period;
    bit          chan_only = 1'b0;

    always #2 aclk = ~aclk;

    t1pei_top u_t1pei_top (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .tx_valid(tx_valid), .tx_bit(tx_bit), .tx_fbit(tx_fbit), .tx_frame_start(tx_frame_start),
        .tx_channel(tx_channel), .line_valid(line_valid), .line_bit(line_bit), .line_error_inserted(line_err)
    );
    t1pei_stream_src u_t1pei_stream_src (
        .aclk(aclk), .aresetn(aresetn), .run(run), .tx_valid(tx_valid), .tx_bit(tx_bit),
        .tx_fbit(tx_fbit), .tx_frame_start(tx_frame_start), .tx_channel(tx_channel)
    );
    ////////////////////////////////////////
    task automatic fail(input string m);
        err_count++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) fail(m);
    endtask
    task automatic report_and_stop;
        $display("mismatches %0d, checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awaddr <= {2'b00, idx, 2'b00};
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        resp = bresp;
        bready <= 1'b0;
        if (n == 50) begin
            fail("write timeout");
            report_and_stop;
        end
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er = 2'h0);
        int n;
        @(posedge aclk);
        araddr <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 50) begin
            fail("read timeout");
            report_and_stop;
        end
        chk(rdata, exp, "read data");
        chk(rresp, er, "read response");
    endtask
    // control written with the load strobe low, then raised
    task automatic setup(input logic [7:0] ctrl);
        wr(t1pei_pkg::IDX_RATE_CTRL, {24'h0, ctrl});
        wr(t1pei_pkg::IDX_RATE_CTRL, {24'h0, ctrl | 8'h80});
    endtask
    task automatic burst(input int frames, input int exp);
        cnt = 0;
        errs = 0;
        @(posedge aclk);
        run <= 1'b1;
        repeat (frames * 193) @(posedge aclk);
        run <= 1'b0;
        repeat (4) @(posedge aclk);
        chk(errs, exp, "error total");
    endtask
    ////////////////////////////////////////
    // line side lags the stream by one cycle
    always @(posedge aclk) begin
        if (aresetn === 1'b1 && line_valid !== d_val) fail("line valid");
        if (line_valid === 1'b1) begin
            if ((line_bit ^ line_err) !== d_bit) fail("line bit");
            if (d_fbit === 1'b1 && line_err !== 1'b0) fail("framing bit inverted");
            if (!d_fbit && (!chan_only || d_ch == 5'h00)) cnt++;
            if (line_err === 1'b1) begin
                errs++;
                chk(cnt, period, "error spacing");
                cnt = 0;
            end
        end
        d_val = tx_valid;
        d_bit = tx_bit;
        d_fbit = tx_fbit;
        d_ch = tx_channel;
    end
    ////////////////////////////////////////
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++) rchk(8'hEB + 8'(i), 32'h0);
        rchk(8'h00, 32'h0, t1pei_pkg::RESP_SLVERR);
        wr(t1pei_pkg::IDX_REMAIN_LOW, 32'h5);
        chk(resp, t1pei_pkg::RESP_SLVERR, "read-only write");
        wr(t1pei_pkg::IDX_CONFIG, 32'h1);
        wr(t1pei_pkg::IDX_RATE_CTRL, 32'h01);
        wr(t1pei_pkg::IDX_COUNT_LOW, 32'h03);
        wr(t1pei_pkg::IDX_COUNT_HIGH, 32'h02);
        wr(t1pei_pkg::IDX_RATE_CTRL, 32'h81);
        rchk(t1pei_pkg::IDX_REMAIN_LOW, 32'h03);
        rchk(t1pei_pkg::IDX_REMAIN_HIGH, 32'h02);
        period = 16;
        burst(43, 515);
        rchk(t1pei_pkg::IDX_REMAIN_LOW, 32'h00);
        wr(t1pei_pkg::IDX_COUNT_LOW, 32'h05);
        wr(t1pei_pkg::IDX_COUNT_HIGH, 32'h00);
        wr(t1pei_pkg::IDX_RATE_CTRL, 32'h81);
        rchk(t1pei_pkg::IDX_REMAIN_LOW, 32'h00);
        setup(8'h01);
        rchk(t1pei_pkg::IDX_REMAIN_LOW, 32'h05);
        strb <= 4'hE;
        wr(t1pei_pkg::IDX_COUNT_LOW, 32'hFF);
        strb <= 4'hF;
        rchk(t1pei_pkg::IDX_COUNT_LOW, 32'h05);
        wr(t1pei_pkg::IDX_COUNT_LOW, 32'h00);
        setup(8'h01);
        burst(1, 0);
        wr(t1pei_pkg::IDX_COUNT_LOW, 32'h02);
        for (int n = 1; n < 6; n++) begin
            period = 1 << (n + 3);
            setup(8'h10 | 8'(n));
            burst(2, 384 / period);
        end
        rchk(t1pei_pkg::IDX_REMAIN_LOW, 32'h02);
        setup(8'h10);
        burst(1, 0);
        wr(t1pei_pkg::IDX_CONFIG, 32'h0);
        setup(8'h11);
        burst(1, 0);
        wr(t1pei_pkg::IDX_CONFIG, 32'h3);
        wr(t1pei_pkg::IDX_CHAN_MASK, 32'h1);
        chan_only = 1'b1;
        period = 16;
        setup(8'h11);
        burst(4, 2);
        report_and_stop;
    end
endmodule // t1_payload_error_inserter_bench
